// >>> logic/bbie_pkg.sv
// constants for the bit-manipulation and conditional-branch executor
// assumes: Avalon-MM slave with 32-bit data, byte addresses on a 5-bit port
package bbie_pkg;
  // ********************************
  // register map (byte addresses)
  // ********************************
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_INSTR = 5'h04;
  localparam logic [4:0] OFS_ACC = 5'h08;
  localparam logic [4:0] OFS_PSW = 5'h0C;
  localparam logic [4:0] OFS_PC = 5'h10;
  localparam logic [4:0] OFS_STAT = 5'h14;
  localparam logic [4:0] OFS_MADDR = 5'h18;
  localparam logic [4:0] OFS_MDATA = 5'h1C;
  localparam int CTRL_START = 0;
  localparam int STAT_BUSY = 0;
  localparam int STAT_ILL = 1;
  localparam int STAT_TAKEN = 2;
  localparam int STAT_CYC_LO = 8;
  // ********************************
  // flags and reset values
  // ********************************
  localparam int PSW_N = 7;
  localparam int PSW_V = 6;
  localparam int PSW_G = 5;
  localparam int PSW_Z = 1;
  localparam int PSW_C = 0;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] PSW_RST = 8'h00;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam int MEM_AW = 9;
  localparam int MEM_WORDS = 512;
  // ********************************
  // operand layout of bit-address forms
  // ********************************
  localparam int OPB_BIT_HI = 15;
  localparam int OPB_BIT_LO = 13;
  localparam int OPB_INV = 12;
  // ********************************
  // opcodes
  // ********************************
  localparam logic [7:0] OP_AND = 8'h8B;
  localparam logic [7:0] OP_XOR = 8'hAB;
  localparam logic [7:0] OP_LDC = 8'hCB;
  localparam logic [7:0] OP_NOT = 8'h4B;
  localparam logic [7:0] OP_OR = 8'h6B;
  localparam logic [7:0] OP_STC = 8'hEB;
  localparam logic [7:0] OP_BIT_DP = 8'h0C;
  localparam logic [7:0] OP_BIT_ABS = 8'h1C;
  localparam logic [7:0] OP_TCLR = 8'h5C;
  localparam logic [7:0] OP_TSET = 8'h3C;
  localparam logic [7:0] OP_CLRA = 8'h2B;
  localparam logic [7:0] OP_SETA = 8'h0B;
  localparam logic [7:0] OP_CARRY_CLEAR = 8'h20;
  localparam logic [7:0] OP_CARRY_SET = 8'hA0;
  localparam logic [7:0] OP_PAGE_SEL_CLEAR = 8'h40;
  localparam logic [7:0] OP_PAGE_SEL_SET = 8'hC0;
  localparam logic [7:0] OP_OVERFLOW_CLEAR = 8'h80;
  localparam logic [7:0] OP_BCC = 8'h50;
  localparam logic [7:0] OP_BCS = 8'hD0;
  localparam logic [7:0] OP_BEQ = 8'hF0;
  localparam logic [7:0] OP_BNE = 8'h70;
  localparam logic [7:0] OP_BMI = 8'h90;
  localparam logic [3:0] LO_DPBIT = 4'h1;
  localparam logic [3:0] LO_BR_ABIT = 4'h2;
  localparam logic [3:0] LO_BR_DPBIT = 4'h3;
  // ********************************
  // lengths and cycle counts
  // ********************************
  localparam logic [15:0] LEN_1 = 16'h0001;
  localparam logic [15:0] LEN_2 = 16'h0002;
  localparam logic [15:0] LEN_3 = 16'h0003;
  localparam logic [3:0] CYC_ILL = 4'h1;
  localparam logic [3:0] CYC_FLAG = 4'h2;
  localparam logic [3:0] CYC_ACCBIT = 4'h2;
  localparam logic [3:0] CYC_AND_LDC = 4'h4;
  localparam logic [3:0] CYC_XOR_OR_NOT = 4'h5;
  localparam logic [3:0] CYC_STC_TEST = 4'h6;
  localparam logic [3:0] CYC_BIT_DP = 4'h4;
  localparam logic [3:0] CYC_BIT_ABS = 4'h5;
  localparam logic [3:0] CYC_DPBIT = 4'h4;
  localparam logic [3:0] CYC_BR_FLAG = 4'h2;
  localparam logic [3:0] CYC_BR_ABIT = 4'h4;
  localparam logic [3:0] CYC_BR_DPBIT = 4'h5;
  localparam logic [3:0] CYC_BR_EXTRA = 4'h2;
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_EXEC = 2'b10} bbie_state_t;
endpackage : bbie_pkg

// >>> logic/bbie_exec.sv
// executor for bit-manipulation and conditional-branch instructions
// assumes: Avalon-MM slave with waitrequest, one clock, synchronous reset
// Functional notes
// - carry AND memory bit, or its inverse; opcode 8B, three bytes, four cycles.
// - bit test sets Z from A AND M, N from M7, V from M6.
// - direct-page bit clear writes zero into the chosen memory bit.
// - direct-page bit set writes one into the chosen memory bit.
// - accumulator bit clear 2B and bit set 0B force one A bit.
// - carry clear 20 forces C low, carry set A0 forces C high.
// - page select clear 40 forces G low, set C0 forces G high.
// - overflow clear 80 forces V low.
// - carry XOR memory bit, or its inverse; opcode AB, five cycles.
// - load carry copies the memory bit, or its inverse, in four cycles.
// - memory bit invert 4B flips the bit and leaves flags alone.
// - carry OR memory bit, or its inverse; opcode 6B, five cycles.
// - store carry EB writes C into the memory bit in six cycles.
// - test-and-clear 5C sets N,Z from A-M, writes M AND NOT A.
// - test-and-set 3C sets N,Z from A-M, writes M OR A.
// - branch on bit zero, accumulator 4/6 cycles, direct page 5/7.
// - branch on bit one when bit is 1; accumulator form low nibble 2.
// - carry branches 50 on C=0 and D0 on C=1, 2/4 cycles.
// - zero-flag branches F0 on Z=1 and 70 on Z=0, 2/4 cycles.
// - negative branch 90 taken when N=1, 2/4 cycles.
`timescale 1ns/1ps
module bbie_exec (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST
);
  // ********************************
  // state
  // ********************************
  bbie_pkg::bbie_state_t state_q, state_d;
  wire [23:0] instr_q;
  logic [7:0] acc_q;
  logic [7:0] psw_q;
  logic [15:0] pc_q;
  logic [3:0] cnt_q;
  logic [3:0] cyc_q;
  logic ill_q;
  logic taken_q;
  logic [bbie_pkg::MEM_AW-1:0] maddr_q;
  logic [7:0] mem_q [bbie_pkg::MEM_WORDS];
  logic wait_q;
  logic [31:0] rdata_q;

  // ********************************
  // bus decode
  // ********************************
  // a request waits one cycle, so read data is a registered copy of state
  wire busy = (state_q == bbie_pkg::ST_EXEC);
  wire acc_cyc = (AVS_READ | AVS_WRITE) & ~wait_q;
  wire wr = acc_cyc & AVS_WRITE & AVS_BYTEENABLE[0];
  wire wr_idle = wr & ~busy;
  wire sel_ctrl = (AVS_ADDRESS == bbie_pkg::OFS_CTRL);
  wire sel_instr = (AVS_ADDRESS == bbie_pkg::OFS_INSTR);
  wire sel_acc = (AVS_ADDRESS == bbie_pkg::OFS_ACC);
  wire sel_psw = (AVS_ADDRESS == bbie_pkg::OFS_PSW);
  wire sel_pc = (AVS_ADDRESS == bbie_pkg::OFS_PC);
  wire sel_stat = (AVS_ADDRESS == bbie_pkg::OFS_STAT);
  wire sel_maddr = (AVS_ADDRESS == bbie_pkg::OFS_MADDR);
  wire sel_mdata = (AVS_ADDRESS == bbie_pkg::OFS_MDATA);
  wire start = wr_idle & sel_ctrl & AVS_WRITEDATA[bbie_pkg::CTRL_START];
  wire [31:0] stat_word = {20'h00000, cyc_q, 5'h00, taken_q, ill_q, busy};
  wire [31:0] rd_mux =
    sel_instr ? {8'h00, instr_q} :
    sel_acc ? {24'h000000, acc_q} :
    sel_psw ? {24'h000000, psw_q} :
    sel_pc ? {16'h0000, pc_q} :
    sel_stat ? stat_word :
    sel_maddr ? {23'h000000, maddr_q} :
    sel_mdata ? {24'h000000, mem_q[maddr_q]} : 32'h00000000;

  // ********************************
  // instruction decode
  // ********************************
  wire [7:0] opc = instr_q[7:0];
  wire [7:0] b1 = instr_q[15:8];
  wire [7:0] b2 = instr_q[23:16];
  wire [15:0] bw = {b2, b1};
  wire [3:0] lo = opc[3:0];
  wire is_and = (opc == bbie_pkg::OP_AND);
  wire is_xor = (opc == bbie_pkg::OP_XOR);
  wire is_ldc = (opc == bbie_pkg::OP_LDC);
  wire is_not = (opc == bbie_pkg::OP_NOT);
  wire is_or = (opc == bbie_pkg::OP_OR);
  wire is_stc = (opc == bbie_pkg::OP_STC);
  wire is_bdp = (opc == bbie_pkg::OP_BIT_DP);
  wire is_babs = (opc == bbie_pkg::OP_BIT_ABS);
  wire is_tclr = (opc == bbie_pkg::OP_TCLR);
  wire is_tset = (opc == bbie_pkg::OP_TSET);
  wire is_clra = (opc == bbie_pkg::OP_CLRA);
  wire is_seta = (opc == bbie_pkg::OP_SETA);
  wire is_carry_clear = (opc == bbie_pkg::OP_CARRY_CLEAR);
  wire is_carry_set = (opc == bbie_pkg::OP_CARRY_SET);
  wire is_page_sel_clear = (opc == bbie_pkg::OP_PAGE_SEL_CLEAR);
  wire is_page_sel_set = (opc == bbie_pkg::OP_PAGE_SEL_SET);
  wire is_overflow_clear = (opc == bbie_pkg::OP_OVERFLOW_CLEAR);
  wire is_bcc = (opc == bbie_pkg::OP_BCC);
  wire is_bcs = (opc == bbie_pkg::OP_BCS);
  wire is_beq = (opc == bbie_pkg::OP_BEQ);
  wire is_bne = (opc == bbie_pkg::OP_BNE);
  wire is_bmi = (opc == bbie_pkg::OP_BMI);
  // even high nibble sets or branches on one, odd high nibble clears or branches on zero
  wire is_mset = (lo == bbie_pkg::LO_DPBIT) & ~opc[4];
  wire is_mclr = (lo == bbie_pkg::LO_DPBIT) & opc[4];
  wire is_bra = (lo == bbie_pkg::LO_BR_ABIT);
  wire is_brd = (lo == bbie_pkg::LO_BR_DPBIT);
  wire g_mbit = is_and | is_xor | is_ldc | is_not | is_or | is_stc;
  wire g_one = is_carry_clear | is_carry_set | is_page_sel_clear | is_page_sel_set | is_overflow_clear;
  wire g_brf = is_bcc | is_bcs | is_beq | is_bne | is_bmi;
  wire g_acc = is_clra | is_seta;
  wire g_test = is_tclr | is_tset;
  wire legal = g_mbit | g_one | g_brf | g_acc | g_test | is_bdp | is_babs
             | is_mset | is_mclr | is_bra | is_brd;

  // ********************************
  // operands
  // ********************************
  // the memory holds 512 bytes: G picks the direct page, absolute forms
  // keep only the low nine address bits
  wire dp_form = is_bdp | is_mset | is_mclr | is_brd;
  wire [bbie_pkg::MEM_AW-1:0] dp_addr = {psw_q[bbie_pkg::PSW_G], b1};
  wire [bbie_pkg::MEM_AW-1:0] ea = dp_form ? dp_addr : bw[bbie_pkg::MEM_AW-1:0];
  wire [7:0] mem_rd = mem_q[ea];
  wire opc_bit = is_mset | is_mclr | is_bra | is_brd;
  wire [2:0] bsel = opc_bit ? opc[7:5] : g_acc ? b1[2:0]
                  : bw[bbie_pkg::OPB_BIT_HI:bbie_pkg::OPB_BIT_LO];
  wire [7:0] mask = 8'h01 << bsel;
  wire m_bit = mem_rd[bsel];
  wire mbe = m_bit ^ bw[bbie_pkg::OPB_INV];
  wire c_f = psw_q[bbie_pkg::PSW_C];
  wire z_f = psw_q[bbie_pkg::PSW_Z];
  wire n_f = psw_q[bbie_pkg::PSW_N];
  wire [7:0] diff = acc_q - mem_rd;

  // ********************************
  // branch condition, length and timing
  // ********************************
  wire br_cond =
    is_bra ? (acc_q[bsel] == ~opc[4]) :
    is_brd ? (m_bit == ~opc[4]) :
    is_bcc ? ~c_f : is_bcs ? c_f :
    is_beq ? z_f : is_bne ? ~z_f :
    is_bmi ? n_f : 1'b0;
  wire [7:0] rel = is_brd ? b2 : b1;
  wire [15:0] len = g_one ? bbie_pkg::LEN_1
                  : (g_mbit | is_babs | g_test | is_brd) ? bbie_pkg::LEN_3 : bbie_pkg::LEN_2;
  wire [15:0] pc_next = pc_q + (legal ? len : 16'h0000);
  wire [15:0] pc_br = pc_next + {{8{rel[7]}}, rel};
  wire [3:0] cyc_nt =
    (is_and | is_ldc) ? bbie_pkg::CYC_AND_LDC :
    (is_xor | is_or | is_not) ? bbie_pkg::CYC_XOR_OR_NOT :
    (is_stc | g_test) ? bbie_pkg::CYC_STC_TEST :
    is_bdp ? bbie_pkg::CYC_BIT_DP : is_babs ? bbie_pkg::CYC_BIT_ABS :
    (is_mset | is_mclr) ? bbie_pkg::CYC_DPBIT :
    g_acc ? bbie_pkg::CYC_ACCBIT : g_one ? bbie_pkg::CYC_FLAG :
    g_brf ? bbie_pkg::CYC_BR_FLAG : is_bra ? bbie_pkg::CYC_BR_ABIT :
    is_brd ? bbie_pkg::CYC_BR_DPBIT : bbie_pkg::CYC_ILL;
  wire [3:0] cyc_all = cyc_nt + (br_cond ? bbie_pkg::CYC_BR_EXTRA : 4'h0);

  // ********************************
  // results
  // ********************************
  wire c_new = is_and ? (c_f & mbe) : is_or ? (c_f | mbe) :
               is_xor ? (c_f ^ mbe) : is_ldc ? mbe :
               is_carry_clear ? 1'b0 : is_carry_set ? 1'b1 : c_f;
  wire g_new = is_page_sel_clear ? 1'b0 : is_page_sel_set ? 1'b1 : psw_q[bbie_pkg::PSW_G];
  wire bit_t = is_bdp | is_babs;
  wire v_new = is_overflow_clear ? 1'b0 : bit_t ? mem_rd[6] : psw_q[bbie_pkg::PSW_V];
  wire n_new = bit_t ? mem_rd[7] : g_test ? diff[7] : n_f;
  wire z_new = bit_t ? ((acc_q & mem_rd) == 8'h00) :
               g_test ? (diff == 8'h00) : z_f;
  wire [7:0] psw_new = {n_new, v_new, g_new, psw_q[4:2], z_new, c_new};
  wire [7:0] acc_new = is_seta ? (acc_q | mask) : is_clra ? (acc_q & ~mask) : acc_q;
  wire nb = is_not ? ~m_bit : is_stc ? c_f : is_mset;
  wire [7:0] mem_new = is_tclr ? (mem_rd & ~acc_q) :
                       is_tset ? (mem_rd | acc_q) :
                       nb ? (mem_rd | mask) : (mem_rd & ~mask);
  wire mem_wx = is_not | is_stc | is_mset | is_mclr | g_test;
  wire commit = busy & (cnt_q == 4'h1);
  wire mem_we = (commit & mem_wx) | (wr_idle & sel_mdata);
  wire [bbie_pkg::MEM_AW-1:0] mem_wa = busy ? ea : maddr_q;
  wire [7:0] mem_wd = busy ? mem_new : AVS_WRITEDATA[7:0];

  // ********************************
  // sequencer
  // ********************************
  // all effects land in the last cycle, so a read-modify-write never
  // sees a partly updated operand
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      bbie_pkg::ST_IDLE:
      begin
        if (start)
          state_d = bbie_pkg::ST_EXEC;
      end
      bbie_pkg::ST_EXEC:
      begin
        if (commit)
          state_d = bbie_pkg::ST_IDLE;
      end
      default:
        state_d = bbie_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      state_q <= bbie_pkg::ST_IDLE;
      cnt_q <= 4'h0;
      cyc_q <= 4'h0;
      ill_q <= 1'b0;
      taken_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      if (start)
      begin
        cnt_q <= cyc_all;
        cyc_q <= cyc_all;
        ill_q <= ~legal;
        taken_q <= br_cond;
      end
      else if (busy)
        cnt_q <= cnt_q - 4'h1;
    end
  end

  // ********************************
  // architectural registers
  // ********************************
  // software may only touch them while idle; writes during a run are dropped
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      acc_q <= bbie_pkg::ACC_RST;
      psw_q <= bbie_pkg::PSW_RST;
      pc_q <= bbie_pkg::PC_RST;
      maddr_q <= '0;
    end
    else if (commit)
    begin
      acc_q <= acc_new;
      psw_q <= psw_new;
      pc_q <= taken_q ? pc_br : pc_next;
    end
    else if (wr_idle)
    begin
      if (sel_acc)
        acc_q <= AVS_WRITEDATA[7:0];
      if (sel_psw)
        psw_q <= AVS_WRITEDATA[7:0];
      if (sel_pc)
        pc_q <= AVS_WRITEDATA[15:0];
      if (sel_maddr)
        maddr_q <= AVS_WRITEDATA[bbie_pkg::MEM_AW-1:0];
    end
  end

  // instruction bytes honour byte enables; one flop group per lane
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_instr
      logic [7:0] lane_q;
      always_ff @(posedge SYS_CLK)
      begin
        if (SYS_RST)
          lane_q <= 8'h00;
        else if (acc_cyc & AVS_WRITE & ~busy & sel_instr & AVS_BYTEENABLE[gi])
          lane_q <= AVS_WRITEDATA[gi*8 +: 8];
      end
      assign instr_q[gi*8 +: 8] = lane_q;
    end
  endgenerate

  always_ff @(posedge SYS_CLK)
  begin
    if (mem_we)
      mem_q[mem_wa] <= mem_wd;
  end

  // ********************************
  // bus answer
  // ********************************
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      wait_q <= 1'b1;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      wait_q <= ~((AVS_READ | AVS_WRITE) & wait_q);
      if (AVS_READ & wait_q)
        rdata_q <= rd_mux;
    end
  end

  assign AVS_WAITREQUEST = wait_q;
  assign AVS_READDATA = rdata_q;

  // ********************************
  // checks
  // ********************************
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);

  chk_and_carry: assert property (
    commit && is_and |=> psw_q[0] == ($past(c_f) & $past(mbe)))
    else $error("carry AND result wrong");
  chk_bit_test: assert property (
    commit && bit_t |=> psw_q[1] == ($past(acc_q & mem_rd) == 8'h00)
      && psw_q[7] == $past(mem_rd[7]) && psw_q[6] == $past(mem_rd[6]))
    else $error("bit test flags wrong");
  chk_mem_clear: assert property (
    commit && is_mclr |=> (mem_q[$past(ea)] & $past(mask)) == 8'h00)
    else $error("memory bit not cleared");
  chk_acc_set: assert property (
    commit && is_seta |=> (acc_q & $past(mask)) != 8'h00)
    else $error("accumulator bit not set");
  chk_flag_ops: assert property (
    commit && is_carry_set |=> psw_q[0] && $stable(psw_q[7:1]))
    else $error("carry set wrong");
  chk_overflow_clear_flag: assert property (
    commit && is_overflow_clear |=> !psw_q[6])
    else $error("overflow not cleared");
  chk_stc_store: assert property (
    commit && is_stc |=> mem_q[$past(ea)][$past(bsel)] == $past(c_f))
    else $error("carry not stored");
  chk_tset_write: assert property (
    commit && is_tset |=> mem_q[$past(ea)] == $past(mem_rd | acc_q)
      && psw_q[1] == ($past(diff) == 8'h00))
    else $error("test and set wrong");
  chk_brf_time: assert property (
    start && g_brf && !br_cond |=> busy [*2] ##1 !busy)
    else $error("untaken flag branch length wrong");
  chk_brf_taken: assert property (
    start && g_brf && br_cond |=> busy [*4] ##1 (!busy && pc_q == $past(pc_br, 5)))
    else $error("taken flag branch wrong");
  chk_bus_wait: assert property (
    (AVS_READ || AVS_WRITE) && wait_q |=> !wait_q ##1 wait_q)
    else $error("waitrequest handshake wrong");

  cov_taken: cover property (commit && taken_q && is_brd);
  cov_not_taken: cover property (commit && !taken_q && is_bra);
  cov_rmw: cover property (commit && is_tclr);
  cov_illegal: cover property (commit && ill_q);
endmodule : bbie_exec

// >>> bench/bbie_host.sv
// host model: Avalon-MM master that reaches the executor registers
// assumes: the slave drops waitrequest for one cycle per request, outputs move on NBA
`timescale 1ns/1ps
module bbie_host (
  input wire logic clk,
  output logic [4:0] address,
  output logic read,
  output logic write,
  output logic [31:0] writedata,
  output logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest
);
  initial
  begin
    address = 5'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h00000000;
    byteenable = 4'hF;
  end
  // ********************************
  // bus cycles
  // ********************************
  // the leading edge keeps two requests from landing in one time step
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk);
    address <= a;
    writedata <= d;
    byteenable <= be;
    write <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    write <= 1'b0;
    // released data must not keep looking valid
    writedata <= ~d;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk);
    address <= a;
    byteenable <= 4'hF;
    read <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    d = readdata;
    read <= 1'b0;
  endtask : rd
endmodule : bbie_host

// >>> bench/bbie_exec_test.sv
// self-checking bench for the bit and branch executor
// assumes: bbie_host drives the register bus; one 50 MHz clock
`timescale 1ns/1ps
module bbie_exec_test;
  typedef struct packed {
    logic [23:0] ins;
    logic [7:0] a;
    logic [7:0] p;
    logic [7:0] m;
    logic [7:0] ea;
    logic [7:0] ep;
    logic [15:0] epc;
    logic [7:0] em;
    logic [3:0] cyc;
    logic tk;
  } bbie_row_t;
  logic sys_clk;
  logic sys_rst;
  logic [4:0] av_address;
  logic av_read;
  logic av_write;
  logic [31:0] av_writedata;
  logic [3:0] av_byteenable;
  logic [31:0] av_readdata;
  logic av_waitrequest;
  int n_mismatch = 0;
  int tests_run = 0;
  // ********************************
  // table: instr, A, PSW, M, then A, PSW, PC, M, cycles, taken; memory at 0A5, PC from 0100
  // ********************************
  bbie_row_t rows [0:31] = '{
    '{24'h60A58B, 8'h00, 8'h01, 8'hF7, 8'h00, 8'h00, 16'h0103, 8'hF7, 4'h4, 1'b0},
    '{24'h70A58B, 8'h00, 8'h01, 8'hF7, 8'h00, 8'h01, 16'h0103, 8'hF7, 4'h4, 1'b0},
    '{24'h00A5AB, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 16'h0103, 8'h01, 4'h5, 1'b0},
    '{24'h10A5AB, 8'h00, 8'h01, 8'h01, 8'h00, 8'h01, 16'h0103, 8'h01, 4'h5, 1'b0},
    '{24'hE0A5CB, 8'h00, 8'h00, 8'h80, 8'h00, 8'h01, 16'h0103, 8'h80, 4'h4, 1'b0},
    '{24'hF0A5CB, 8'h00, 8'h01, 8'h80, 8'h00, 8'h00, 16'h0103, 8'h80, 4'h4, 1'b0},
    '{24'h40A54B, 8'h00, 8'hC3, 8'h00, 8'h00, 8'hC3, 16'h0103, 8'h04, 4'h5, 1'b0},
    '{24'h20A56B, 8'h00, 8'h00, 8'h02, 8'h00, 8'h01, 16'h0103, 8'h02, 4'h5, 1'b0},
    '{24'h30A56B, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 16'h0103, 8'h02, 4'h5, 1'b0},
    '{24'hA0A5EB, 8'h00, 8'h01, 8'h00, 8'h00, 8'h01, 16'h0103, 8'h20, 4'h6, 1'b0},
    '{24'h00A50C, 8'h0F, 8'h00, 8'hC0, 8'h0F, 8'hC2, 16'h0102, 8'hC0, 4'h4, 1'b0},
    '{24'h00A51C, 8'hFF, 8'hC2, 8'h01, 8'hFF, 8'h00, 16'h0103, 8'h01, 4'h5, 1'b0},
    '{24'h00A55C, 8'h0F, 8'h80, 8'h0F, 8'h0F, 8'h02, 16'h0103, 8'h00, 4'h6, 1'b0},
    '{24'h00A53C, 8'h01, 8'h02, 8'h02, 8'h01, 8'h80, 16'h0103, 8'h03, 4'h6, 1'b0},
    '{24'h00A5D1, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 16'h0102, 8'hBF, 4'h4, 1'b0},
    '{24'h00A5C1, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 16'h0102, 8'h40, 4'h4, 1'b0},
    '{24'h00042B, 8'hFF, 8'h00, 8'h00, 8'hEF, 8'h00, 16'h0102, 8'h00, 4'h2, 1'b0},
    '{24'h00070B, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 16'h0102, 8'h00, 4'h2, 1'b0},
    '{24'h000020, 8'h00, 8'hFF, 8'h00, 8'h00, 8'hFE, 16'h0101, 8'h00, 4'h2, 1'b0},
    '{24'h0000A0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 16'h0101, 8'h00, 4'h2, 1'b0},
    '{24'h000040, 8'h00, 8'hFF, 8'h00, 8'h00, 8'hDF, 16'h0101, 8'h00, 4'h2, 1'b0},
    '{24'h0000C0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 16'h0101, 8'h00, 4'h2, 1'b0},
    '{24'h000080, 8'h00, 8'hFF, 8'h00, 8'h00, 8'hBF, 16'h0101, 8'h00, 4'h2, 1'b0},
    '{24'h00F050, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 16'h00F2, 8'h00, 4'h4, 1'b1},
    '{24'h0010D0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 16'h0102, 8'h00, 4'h2, 1'b0},
    '{24'h0005F0, 8'h00, 8'h02, 8'h00, 8'h00, 8'h02, 16'h0107, 8'h00, 4'h4, 1'b1},
    '{24'h000570, 8'h00, 8'h02, 8'h00, 8'h00, 8'h02, 16'h0102, 8'h00, 4'h2, 1'b0},
    '{24'h008090, 8'h00, 8'h80, 8'h00, 8'h00, 8'h80, 16'h0082, 8'h00, 4'h4, 1'b1},
    '{24'h000432, 8'hFD, 8'h00, 8'h00, 8'hFD, 8'h00, 16'h0106, 8'h00, 4'h6, 1'b1},
    '{24'h000422, 8'hFD, 8'h00, 8'h00, 8'hFD, 8'h00, 16'h0102, 8'h00, 4'h4, 1'b0},
    '{24'hFEA513, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 16'h0103, 8'h01, 4'h5, 1'b0},
    '{24'hFEA503, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 16'h0101, 8'h01, 4'h7, 1'b1}
  };
  bbie_host host (.clk(sys_clk), .address(av_address), .read(av_read), .write(av_write),
    .writedata(av_writedata), .byteenable(av_byteenable), .readdata(av_readdata),
    .waitrequest(av_waitrequest));
  bbie_exec dut (.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .AVS_ADDRESS(av_address),
    .AVS_READ(av_read), .AVS_WRITE(av_write), .AVS_WRITEDATA(av_writedata),
    .AVS_BYTEENABLE(av_byteenable), .AVS_READDATA(av_readdata),
    .AVS_WAITREQUEST(av_waitrequest));
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // ********************************
  // checking and execution helpers
  // ********************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic rd_chk(input string what, input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] d;
    host.rd(a, d);
    chk(what, exp, d);
  endtask : rd_chk
  // poke writes ACC while busy; that write must be dropped
  task automatic run(input bbie_row_t r, input bit poke, input bit ill);
    logic [31:0] st;
    int n;
    host.wr(bbie_pkg::OFS_MADDR, 32'h000000A5, 4'hF);
    host.wr(bbie_pkg::OFS_MDATA, {24'h000000, r.m}, 4'hF);
    host.wr(bbie_pkg::OFS_ACC, {24'h000000, r.a}, 4'hF);
    host.wr(bbie_pkg::OFS_PSW, {24'h000000, r.p}, 4'hF);
    host.wr(bbie_pkg::OFS_PC, 32'h00000100, 4'hF);
    host.wr(bbie_pkg::OFS_INSTR, {8'h00, r.ins}, 4'hF);
    host.wr(bbie_pkg::OFS_CTRL, 32'h00000001, 4'hF);
    if (poke)
      host.wr(bbie_pkg::OFS_ACC, 32'h00000055, 4'hF);
    n = 0;
    st = 32'h00000001;
    while (st[bbie_pkg::STAT_BUSY] !== 1'b0 && n < 40)
    begin
      host.rd(bbie_pkg::OFS_STAT, st);
      n++;
    end
    chk("busy_end", 32'h00000000, {31'h0, st[bbie_pkg::STAT_BUSY]});
    rd_chk("acc", bbie_pkg::OFS_ACC, {24'h000000, r.ea});
    rd_chk("psw", bbie_pkg::OFS_PSW, {24'h000000, r.ep});
    rd_chk("pc", bbie_pkg::OFS_PC, {16'h0000, r.epc});
    rd_chk("mem", bbie_pkg::OFS_MDATA, {24'h000000, r.em});
    rd_chk("stat", bbie_pkg::OFS_STAT, {20'h00000, r.cyc, 5'h00, r.tk, ill, 1'b0});
  endtask : run
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report
  // ********************************
  // main sequence
  // ********************************
  initial
  begin
    sys_rst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk("wait_in_reset", 32'h00000001, {31'h0, av_waitrequest});
    sys_rst <= 1'b0;
    rd_chk("acc_rst", bbie_pkg::OFS_ACC, 32'h00000000);
    rd_chk("psw_rst", bbie_pkg::OFS_PSW, 32'h00000000);
    rd_chk("pc_rst", bbie_pkg::OFS_PC, 32'h00000000);
    rd_chk("stat_rst", bbie_pkg::OFS_STAT, 32'h00000000);
    $display("reset values done");
    foreach (rows[i])
    begin
      run(rows[i], 1'b0, 1'b0);
      $display("row %0d done", i);
    end
    // write to ACC during a six-cycle run is acknowledged but dropped
    run(rows[13], 1'b1, 1'b0);
    $display("busy refusal done");
    // an opcode outside both groups: no effect, one cycle
    run(bbie_row_t'{24'h0000FF, 8'h5A, 8'h00, 8'h00, 8'h5A, 8'h00, 16'h0100, 8'h00, 4'h1, 1'b0},
      1'b0, 1'b1);
    rd_chk("ill", bbie_pkg::OFS_STAT, 32'h00000102);
    host.wr(bbie_pkg::OFS_ACC, 32'h00000033, 4'hE);
    rd_chk("acc_be", bbie_pkg::OFS_ACC, 32'h0000005A);
    rd_chk("unmapped", 5'h01, 32'h00000000);
    rd_chk("maddr", bbie_pkg::OFS_MADDR, 32'h000000A5);
    // only lane 1 of the instruction word may change
    host.wr(bbie_pkg::OFS_INSTR, 32'h00AABBCC, 4'h2);
    rd_chk("instr_be", bbie_pkg::OFS_INSTR, 32'h0000BBFF);
    $display("refusal cases done");
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd_chk("acc_rst2", bbie_pkg::OFS_ACC, 32'h00000000);
    rd_chk("psw_rst2", bbie_pkg::OFS_PSW, 32'h00000000);
    $display("second reset done");
    final_report();
  end
  // a full run needs under two thousand cycles; this leaves ample margin
  initial
  begin
    repeat (30000) @(posedge sys_clk);
    n_mismatch++;
    final_report();
  end
endmodule : bbie_exec_test
